// ===== core/csb_host.sv
/*
  External agent for the processor system bus: answers reads, takes writes,
  requests the bus, and feeds the boot mode stream after supply-good.
  Assumes device pins are synchronous to core_clk; tristate resolved outside.
*/
//
// Overview of operation
// - 64-bit multiplexed address/data with 8 check bits
// - 9-bit parity-protected command bus, both drive
// - Narrow mode uses 32 bits, 4 check bits
// - Agent alone paces inbound data cycles
// - Command marks address or data, type, last
// - Commands flow both ways over the bus
// - Single datum one to eight bytes
// - Separate read and write accept signals
// - Bus request answered by handover to agent
// - Bus owner flags each valid cycle
// - Read: address, accept, handover, then data
// - Agent returns read data, may own bus
// - Bits supplied from 0 upward to 255
`timescale 1ns/1ns
`default_nettype none
module csb_host
  import csb_pkg::*;
(
  // Clock and reset
  input  wire logic          core_clk,
  input  wire logic          rst,
  // Software register port
  input  wire logic [7:0]    reg_addr,
  input  wire logic [31:0]   reg_wdata,
  input  wire logic          reg_wr,
  input  wire logic          reg_rd,
  output logic      [31:0]   reg_rdata,
  // Device pins
  input  wire csb_pins_in_t  pins_in,
  output csb_pins_out_t      pins_out
);

  typedef enum logic [2:0] {
    ST_IDLE, ST_WR_DATA, ST_RD_WAIT, ST_RD_DATA,
    ST_EXT_WAIT, ST_EXT_OWN, ST_EXT_GIVE
  } csb_state_t;

  csb_state_t state_r;

  logic [3:0]  ctrl_r;
  logic [9:0]  cfg_r;
  logic [3:0]  gap_r;
  logic [31:0] rdata_base_r;
  logic [31:0] last_addr_r;
  logic [31:0] last_wdata_r;
  logic [15:0] wr_cnt_r;
  logic [15:0] drop_cnt_r;
  logic [31:0] reg_rdata_r;

  logic [AD_W-1:0]  ad_r;
  logic [CHK_W-1:0] chk_r;
  logic [CMD_W-1:0] cmd_r;
  logic             cmd_par_r;
  logic             oe_r;
  logic             ivalid_r;
  logic             ext_req_r;
  logic [3:0]       beats_r;
  logic [3:0]       beat_idx_r;
  logic [3:0]       gap_cnt_r;
  logic             wa_d1_r;
  logic             wa_d2_r;
  logic             pipe_used_r;

  logic [BIT_IDX_W-1:0] bit_idx_r;
  logic [4:0]           bit_sel_r;
  logic                 boot_done_r;
  logic                 mclk_d_r;
  logic                 mode_data_r;
  logic [31:0]          mem_word;

  // Per-byte even parity; narrow mode leaves upper four check bits low
  function automatic logic [CHK_W-1:0] check_of(input logic [AD_W-1:0] d,
                                                input logic w32);
    logic [CHK_W-1:0] c;
    c = '0;
    for (int i = 0; i < CHK_W; i++) begin
      c[i] = ^d[i*8 +: 8];
    end
    if (w32) begin
      c[CHK_W-1:4] = 4'h0;
    end
    return c;
  endfunction

  // Stream word zero built from the config fields
  function automatic logic [31:0] stream_word(input logic [9:0] c);
    logic [31:0] w;
    w = 32'h0000_0000;
    w[STR_RATE_LO +: 4] = c[CFG_RATE_LO +: 4];
    w[STR_PLL_LO +: 3]  = c[CFG_PLL_LO +: 3];
    w[STR_WP_LO +: 2]   = c[CFG_WP_LO +: 2];
    w[STR_WIDTH]        = c[CFG_WIDTH];
    return w;
  endfunction

  logic       width32;
  logic [1:0] wproto;
  logic       is_addr;
  logic       is_data;
  logic [2:0] cmd_type;
  logic       wr_issued;

  assign width32  = cfg_r[CFG_WIDTH];
  assign wproto   = cfg_r[CFG_WP_LO +: 2];
  assign is_addr  = pins_in.outbound_valid & ~pins_in.cmd[CMD_DATA_BIT];
  assign is_data  = pins_in.outbound_valid & pins_in.cmd[CMD_DATA_BIT];
  assign cmd_type = pins_in.cmd[CMD_TYPE_LO +: 3];

  // Decide whether a write address cycle counts as issued
  always_comb begin
    case (wproto)
      WP_REISSUE: wr_issued = wa_d2_r & ctrl_r[CTRL_WR_ACC];
      WP_PIPE:    wr_issued = wa_d2_r & (ctrl_r[CTRL_WR_ACC] | ~pipe_used_r);
      default:    wr_issued = 1'b1;
    endcase
  end

  // Software registers
  always_ff @(posedge core_clk) begin
    if (rst) begin
      ctrl_r       <= CTRL_RST;
      cfg_r        <= CFG_RST;
      gap_r        <= GAP_RST;
      rdata_base_r <= RDATA_RST;
    end else if (reg_wr) begin
      case (reg_addr)
        REG_CTRL:  ctrl_r       <= reg_wdata[3:0];
        REG_CFG:   cfg_r        <= reg_wdata[9:0];
        REG_GAP:   gap_r        <= reg_wdata[3:0];
        REG_RDATA: rdata_base_r <= reg_wdata;
        default:   ;
      endcase
    end
  end

  // Read data stand one cycle after the strobe; unmapped reads zero
  always_ff @(posedge core_clk) begin
    if (rst) begin
      reg_rdata_r <= 32'h0000_0000;
    end else if (reg_rd) begin
      case (reg_addr)
        REG_CTRL:  reg_rdata_r <= {28'h0, ctrl_r};
        REG_CFG:   reg_rdata_r <= {22'h0, cfg_r};
        REG_STAT:  reg_rdata_r <= {27'h0, oe_r, ext_req_r,
                                   state_r != ST_IDLE, boot_done_r, ctrl_r[CTRL_SUPPLY]};
        REG_ADDR:  reg_rdata_r <= last_addr_r;
        REG_WDATA: reg_rdata_r <= last_wdata_r;
        REG_RDATA: reg_rdata_r <= rdata_base_r;
        REG_GAP:   reg_rdata_r <= {28'h0, gap_r};
        REG_CNT:   reg_rdata_r <= {drop_cnt_r, wr_cnt_r};
        default:   reg_rdata_r <= 32'h0000_0000;
      endcase
    end else begin
      reg_rdata_r <= 32'h0000_0000;
    end
  end

  // Write-accept history for the two-cycle issue check
  always_ff @(posedge core_clk) begin
    if (rst) begin
      wa_d1_r     <= 1'b0;
      wa_d2_r     <= 1'b0;
      pipe_used_r <= 1'b0;
    end else begin
      wa_d1_r <= ctrl_r[CTRL_WR_ACC];
      wa_d2_r <= wa_d1_r;
      if (ctrl_r[CTRL_WR_ACC]) begin
        pipe_used_r <= 1'b0;
      end else if (state_r == ST_IDLE && is_addr && cmd_type == CMD_T_WRITE
                   && wproto == WP_PIPE && wr_issued) begin
        pipe_used_r <= 1'b1;
      end
    end
  end

  // Transaction engine: one processor request serviced at a time
  always_ff @(posedge core_clk) begin
    if (rst) begin
      state_r      <= ST_IDLE;
      ad_r         <= '0;
      chk_r        <= '0;
      cmd_r        <= '0;
      cmd_par_r    <= 1'b0;
      oe_r         <= 1'b0;
      ivalid_r     <= 1'b0;
      ext_req_r    <= 1'b0;
      beats_r      <= 4'h0;
      beat_idx_r   <= 4'h0;
      gap_cnt_r    <= 4'h0;
      last_addr_r  <= 32'h0000_0000;
      last_wdata_r <= 32'h0000_0000;
      wr_cnt_r     <= 16'h0000;
      drop_cnt_r   <= 16'h0000;
    end else begin
      ivalid_r <= 1'b0;
      case (state_r)
        ST_IDLE: begin
          oe_r <= 1'b0;
          if (is_addr && cmd_type == CMD_T_READ) begin
            last_addr_r <= pins_in.ad[31:0];
            beat_idx_r  <= 4'h0;
            // Single datum is one cycle; device splits wide narrow-mode reads
            beats_r <= pins_in.cmd[CMD_BLOCK_BIT] ? (width32 ? BEATS_32 : BEATS_64)
                                                  : 4'h1;
            state_r <= ST_RD_WAIT;
          end else if (is_addr && cmd_type == CMD_T_WRITE) begin
            if (wr_issued) begin
              last_addr_r <= pins_in.ad[31:0];
              wr_cnt_r    <= wr_cnt_r + 16'h0001;
              beats_r     <= pins_in.cmd[CMD_BLOCK_BIT] ? (width32 ? BEATS_32 : BEATS_64)
                                                        : 4'h1;
              beat_idx_r  <= 4'h0;
              state_r     <= ST_WR_DATA;
            end else begin
              // Counted as dropped, not written; the device repeats this same write
              drop_cnt_r <= drop_cnt_r + 16'h0001;
            end
          end else if (ctrl_r[CTRL_EXT]) begin
            ext_req_r <= 1'b1;
            state_r   <= ST_EXT_WAIT;
          end
        end
        ST_WR_DATA: begin
          if (is_data) begin
            last_wdata_r <= pins_in.ad[31:0];
            beat_idx_r   <= beat_idx_r + 4'h1;
            if (pins_in.cmd[CMD_LAST_BIT] || beat_idx_r + 4'h1 == beats_r) begin
              state_r <= ST_IDLE;
            end
          end
        end
        ST_RD_WAIT: begin
          if (pins_in.release_grant) begin
            oe_r      <= 1'b1;
            gap_cnt_r <= gap_r;
            state_r   <= ST_RD_DATA;
          end
        end
        ST_RD_DATA: begin
          oe_r <= 1'b1;
          if (gap_cnt_r != 4'h0) begin
            gap_cnt_r <= gap_cnt_r - 4'h1;
          end else begin
            ad_r       <= width32 ? {32'h0, rdata_base_r + {28'h0, beat_idx_r}}
                                  : {rdata_base_r, rdata_base_r + {28'h0, beat_idx_r}};
            chk_r      <= check_of(width32 ? {32'h0, rdata_base_r + {28'h0, beat_idx_r}}
                                           : {rdata_base_r, rdata_base_r + {28'h0, beat_idx_r}},
                                   width32);
            cmd_r      <= {1'b1, beat_idx_r + 4'h1 == beats_r, CS_CLEAN, 5'h00};
            cmd_par_r  <= ^{1'b1, beat_idx_r + 4'h1 == beats_r, CS_CLEAN, 5'h00};
            ivalid_r   <= 1'b1;
            beat_idx_r <= beat_idx_r + 4'h1;
            gap_cnt_r  <= gap_r;
            if (beat_idx_r + 4'h1 == beats_r) begin
              state_r <= ST_EXT_GIVE;
            end
          end
        end
        ST_EXT_WAIT: begin
          if (pins_in.release_grant) begin
            oe_r    <= 1'b1;
            state_r <= ST_EXT_OWN;
          end
        end
        ST_EXT_OWN: begin
          oe_r <= 1'b1;
          if (!ctrl_r[CTRL_EXT]) begin
            // A null request hands the bus back to the device
            cmd_r     <= {1'b0, CMD_T_NULL, 5'h00};
            cmd_par_r <= ^{1'b0, CMD_T_NULL, 5'h00};
            ad_r      <= '0;
            chk_r     <= '0;
            ivalid_r  <= 1'b1;
            ext_req_r <= 1'b0;
            state_r   <= ST_EXT_GIVE;
          end
        end
        ST_EXT_GIVE: begin
          // Drivers off one cycle after the final cycle
          oe_r    <= 1'b0;
          state_r <= ST_IDLE;
        end
        default: state_r <= ST_IDLE;
      endcase
    end
  end

  // Boot stream: advance on each rising serial clock from the device
  always_ff @(posedge core_clk) begin
    if (rst) begin
      bit_idx_r   <= '0;
      boot_done_r <= 1'b0;
      mclk_d_r    <= 1'b0;
    end else begin
      mclk_d_r <= pins_in.mode_clock;
      if (!ctrl_r[CTRL_SUPPLY]) begin
        bit_idx_r   <= '0;
        boot_done_r <= 1'b0;
      end else if (pins_in.mode_clock && !mclk_d_r && !boot_done_r) begin
        if (bit_idx_r == CFG_LAST_BIT) begin
          boot_done_r <= 1'b1;
        end else begin
          bit_idx_r <= bit_idx_r + 8'h01;
        end
      end
    end
  end

  // Bit zero already stands when supply-good rises
  always_ff @(posedge core_clk) begin
    if (rst) begin
      bit_sel_r   <= 5'h00;
      mode_data_r <= 1'b0;
    end else begin
      bit_sel_r   <= bit_idx_r[4:0];
      mode_data_r <= boot_done_r ? 1'b0 : mem_word[bit_sel_r];
    end
  end

  csb_mode_mem u_mode_mem (
    .core_clk (core_clk),
    .rst      (rst),
    .we       (reg_wr && reg_addr == REG_CFG),
    .waddr    (3'h0),
    .wdata    (stream_word(reg_wdata[9:0])),
    .raddr    (bit_idx_r[7:5]),
    .rdata    (mem_word)
  );

  assign reg_rdata                     = reg_rdata_r;
  assign pins_out.ad                   = ad_r;
  assign pins_out.chk                  = chk_r;
  assign pins_out.cmd                  = cmd_r;
  assign pins_out.cmd_par              = cmd_par_r;
  assign pins_out.bus_oe               = oe_r;
  assign pins_out.inbound_valid        = ivalid_r;
  assign pins_out.read_accept_ready    = ctrl_r[CTRL_RD_ACC];
  assign pins_out.write_accept_ready   = ctrl_r[CTRL_WR_ACC];
  assign pins_out.external_bus_request = ext_req_r;
  assign pins_out.supply_good          = ctrl_r[CTRL_SUPPLY];
  assign pins_out.mode_data            = mode_data_r;

endmodule // csb_host
`default_nettype wire

// ===== core/csb_pkg.sv
/*
  Shared constants and carrier types for the system bus host controller.
  Assumes a single 125 MHz core clock and synchronous device-side pins.
*/
package csb_pkg;

  // Link widths
  localparam int AD_W    = 64;
  localparam int CHK_W   = 8;
  localparam int CMD_W   = 9;
  localparam int NARROW_W = 32;

  // Boot stream geometry
  localparam int CFG_BITS  = 256;
  localparam int CFG_WORDS = 8;
  localparam int BIT_IDX_W = 8;
  localparam logic [7:0] CFG_LAST_BIT = 8'hff;

  // Software register offsets
  localparam logic [7:0] REG_CTRL  = 8'h00;
  localparam logic [7:0] REG_CFG   = 8'h04;
  localparam logic [7:0] REG_STAT  = 8'h08;
  localparam logic [7:0] REG_ADDR  = 8'h0c;
  localparam logic [7:0] REG_WDATA = 8'h10;
  localparam logic [7:0] REG_RDATA = 8'h14;
  localparam logic [7:0] REG_GAP   = 8'h18;
  localparam logic [7:0] REG_CNT   = 8'h1c;

  // Reset values
  localparam logic [3:0]  CTRL_RST  = 4'h6;
  localparam logic [9:0]  CFG_RST   = 10'h000;
  localparam logic [3:0]  GAP_RST   = 4'h0;
  localparam logic [31:0] RDATA_RST = 32'h0000_0000;

  // Control fields
  localparam int CTRL_SUPPLY = 0;
  localparam int CTRL_RD_ACC = 1;
  localparam int CTRL_WR_ACC = 2;
  localparam int CTRL_EXT    = 3;

  // Config register fields
  localparam int CFG_RATE_LO = 0;
  localparam int CFG_PLL_LO  = 4;
  localparam int CFG_WP_LO   = 7;
  localparam int CFG_WIDTH   = 9;

  // Positions in the boot stream
  localparam int STR_RATE_LO = 1;
  localparam int STR_PLL_LO  = 5;
  localparam int STR_WP_LO   = 9;
  localparam int STR_WIDTH   = 12;

  // Write protocol codes
  localparam logic [1:0] WP_BASIC   = 2'h0;
  localparam logic [1:0] WP_PIPE    = 2'h2;
  localparam logic [1:0] WP_REISSUE = 2'h3;

  // Command encodings
  localparam int CMD_DATA_BIT  = 8;
  localparam int CMD_TYPE_LO   = 5;
  localparam int CMD_BLOCK_BIT = 4;
  localparam int CMD_LAST_BIT  = 7;
  localparam int CMD_CS_LO     = 5;
  localparam logic [2:0] CMD_T_READ  = 3'h0;
  localparam logic [2:0] CMD_T_WRITE = 3'h2;
  localparam logic [2:0] CMD_T_NULL  = 3'h3;
  localparam logic [1:0] CS_CLEAN    = 2'h2;

  // Data cycles per eight-word block
  localparam logic [3:0] BEATS_64 = 4'h4;
  localparam logic [3:0] BEATS_32 = 4'h8;

  typedef struct packed {
    logic [AD_W-1:0]  ad;
    logic [CHK_W-1:0] chk;
    logic [CMD_W-1:0] cmd;
    logic             cmd_par;
    logic             outbound_valid;
    logic             release_grant;
    logic             mode_clock;
  } csb_pins_in_t;

  typedef struct packed {
    logic [AD_W-1:0]  ad;
    logic [CHK_W-1:0] chk;
    logic [CMD_W-1:0] cmd;
    logic             cmd_par;
    logic             bus_oe;
    logic             inbound_valid;
    logic             read_accept_ready;
    logic             write_accept_ready;
    logic             external_bus_request;
    logic             supply_good;
    logic             mode_data;
  } csb_pins_out_t;

endpackage

// ===== core/csb_mode_mem.sv
/*
  Small word memory holding the 256-bit boot mode stream.
  Assumes one writer; read data are registered, one cycle latency.
*/
`timescale 1ns/1ns
`default_nettype none
module csb_mode_mem
  import csb_pkg::*;
(
  // Clock and reset
  input  wire logic        core_clk,
  input  wire logic        rst,
  // Write port
  input  wire logic        we,
  input  wire logic [2:0]  waddr,
  input  wire logic [31:0] wdata,
  // Read port
  input  wire logic [2:0]  raddr,
  output logic      [31:0] rdata
);

  logic [31:0] mem_r [CFG_WORDS];

  // Unused stream bits must read zero, so reset clears all words
  always_ff @(posedge core_clk) begin
    if (rst) begin
      for (int i = 0; i < CFG_WORDS; i++) begin
        mem_r[i] <= 32'h0000_0000;
      end
    end else if (we) begin
      mem_r[waddr] <= wdata;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      rdata <= 32'h0000_0000;
    end else begin
      rdata <= mem_r[raddr];
    end
  end

endmodule // csb_mode_mem
`default_nettype wire

// ===== dv/csb_host_chk.sv
/* Port checker for csb_host, bound to every instance.
   Assumes one clock domain and the package's command layout. */
`timescale 1ns/1ns
`default_nettype none
module csb_host_chk
  import csb_pkg::*;
(
  // Clock and reset
  input wire logic          core_clk,
  input wire logic          rst,
  // Register port
  input wire logic [7:0]    reg_addr,
  input wire logic [31:0]   reg_wdata,
  input wire logic          reg_wr,
  // Device pins
  input wire csb_pins_in_t  pins_in,
  input wire csb_pins_out_t pins_out
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  logic [3:0] beat_n;
  logic [7:0] par_w;
  always_comb for (int i = 0; i < 8; i++) par_w[i] = ^pins_out.ad[8*i +: 8];
  // Beats of the current ownership; cleared whenever the host lets go
  always_ff @(posedge core_clk) begin
    if (rst || !pins_out.bus_oe) beat_n <= 4'h0;
    else if (pins_out.inbound_valid && pins_out.cmd[CMD_DATA_BIT]) beat_n <= beat_n + 4'h1;
  end
  a_accept_from_ctrl: assert property (
    reg_wr && reg_addr == REG_CTRL |=>
    pins_out.write_accept_ready == $past(reg_wdata[CTRL_WR_ACC]) &&
    pins_out.read_accept_ready == $past(reg_wdata[CTRL_RD_ACC]))
    else $error("accept pins differ from control write");
  a_grant_then_oe: assert property ($rose(pins_in.release_grant) |=> pins_out.bus_oe)
    else $error("no drive after handover");
  a_valid_while_oe: assert property (pins_out.inbound_valid |-> pins_out.bus_oe)
    else $error("valid cycle without owning the bus");
  a_cmd_parity_ok: assert property (
    pins_out.inbound_valid |-> pins_out.cmd_par == ^pins_out.cmd)
    else $error("command parity wrong");
  a_check_bits_ok: assert property (
    pins_out.inbound_valid && pins_out.cmd[CMD_DATA_BIT] |-> pins_out.chk == par_w)
    else $error("check bits wrong");
  a_cmd_marks_kind: assert property (pins_out.inbound_valid |-> pins_out.cmd[4:0] == 5'h0 &&
    (pins_out.cmd[CMD_DATA_BIT] ? pins_out.cmd[6:5] == CS_CLEAN : pins_out.cmd[7:5] == CMD_T_NULL))
    else $error("command kind wrong");
  a_null_then_release: assert property (
    pins_out.inbound_valid && !pins_out.cmd[CMD_DATA_BIT] && pins_out.cmd[7:5] == CMD_T_NULL
    |-> !pins_out.external_bus_request ##1 !pins_out.bus_oe)
    else $error("bus kept after null command");
  a_last_ends_owner: assert property (
    pins_out.inbound_valid && pins_out.cmd[CMD_DATA_BIT] && pins_out.cmd[CMD_LAST_BIT]
    |-> beat_n inside {4'h0, 4'h3, 4'h7} ##1 !pins_out.bus_oe)
    else $error("bad beat count or bus kept");
  a_boot_idle_low: assert property (!pins_out.supply_good [*3] |-> !pins_out.mode_data)
    else $error("serial bit high before supply good");
endmodule // csb_host_chk

bind csb_host csb_host_chk u_chk (.core_clk(core_clk), .rst(rst), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .pins_in(pins_in), .pins_out(pins_out));
`default_nettype wire

// ===== dv/csb_dev_model.sv
/* Behavioural processor facing csb_host: boot loader and bus requests.
   Assumes its tasks are called by the bench just after a rising edge. */
`timescale 1ns/1ns
`default_nettype none
module csb_dev_model
  import csb_pkg::*;
#(
  // Boot serial clock divider; shortened by the bench
  parameter int DIV = 256
)
(
  // Clock and reset
  input  wire logic          core_clk,
  input  wire logic          rst,
  // Device pins
  input  wire csb_pins_out_t pins_out,
  output var  csb_pins_in_t  pins_in
);
  logic [CFG_BITS-1:0] stream = '0;
  int                  nbits = 0, div_n = 0, cyc = 0, drops = 0;
  logic                null_seen = 1'b0, grant_req = 1'b0, pused = 1'b0;
  logic [1:0]          wa_hist = 2'b00;
  logic [63:0]         beat_ad[$];
  int                  beat_t[$];
  initial pins_in = '0;

  function automatic logic [7:0] par8(input logic [63:0] d);
    for (int i = 0; i < 8; i++) par8[i] = ^d[8*i +: 8];
  endfunction

  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    wa_hist <= {wa_hist[0], pins_out.write_accept_ready};
    // Serial clock stands still without supply
    if (rst || !pins_out.supply_good) begin
      pins_in.mode_clock <= 1'b0;
      div_n <= 0;
      nbits <= 0;
    end else if (div_n == DIV / 2 - 1) begin
      div_n <= 0;
      pins_in.mode_clock <= !pins_in.mode_clock;
      if (!pins_in.mode_clock && nbits < CFG_BITS) begin
        stream[nbits] <= pins_out.mode_data;
        nbits <= nbits + 1;
      end
    end else div_n <= div_n + 1;
    if ((grant_req || pins_out.external_bus_request) && !pins_out.bus_oe) begin
      pins_in.release_grant <= 1'b1;
    end else pins_in.release_grant <= 1'b0;
    if (pins_out.bus_oe) grant_req <= 1'b0;
    // Extra pipelined write is spent until write accept returns
    if (pins_out.write_accept_ready) pused <= 1'b0;
    if (pins_out.inbound_valid && pins_out.cmd[CMD_DATA_BIT]) begin
      beat_ad.push_back(pins_out.ad);
      beat_t.push_back(cyc);
    end
    if (pins_out.inbound_valid && pins_out.cmd == {1'b0, CMD_T_NULL, 5'h0}) null_seen <= 1'b1;
  end

  task automatic put(input logic [63:0] ad, input logic [8:0] cmd);
    pins_in.ad <= ad;
    pins_in.chk <= par8(ad);
    pins_in.cmd <= cmd;
    pins_in.cmd_par <= ^cmd;
    pins_in.outbound_valid <= 1'b1;
    @(posedge core_clk);
  endtask

  // Released address and command wires change rather than keep a stale value
  task automatic let_go;
    pins_in.ad <= ~pins_in.ad;
    pins_in.cmd <= ~pins_in.cmd;
    pins_in.outbound_valid <= 1'b0;
  endtask

  // Bench waits for each answer, so one request is outstanding
  task automatic do_read(input logic [63:0] addr, input logic blk);
    int n;
    n = 0;
    do begin
      put(addr, {1'b0, CMD_T_READ, blk, 4'h0});
      n++;
    end while (!pins_out.read_accept_ready && n < 50);
    let_go();
    grant_req <= 1'b1;
  endtask

  task automatic do_write(input logic [63:0] addr, input logic [63:0] data);
    int   n;
    logic ok;
    n = 0;
    do begin
      put(addr, {1'b0, CMD_T_WRITE, 5'h0});
      ok = stream[STR_WP_LO +: 2] == WP_BASIC || (wa_hist[1] && (pins_out.write_accept_ready ||
           (stream[STR_WP_LO +: 2] == WP_PIPE && !pused)));
      if (ok && !pins_out.write_accept_ready) pused <= 1'b1;
      if (!ok) drops++;
      put(data, {1'b1, 1'b1, CS_CLEAN, 5'h0});
      n++;
    end while (!ok && n < 50);
    let_go();
  endtask
endmodule // csb_dev_model
`default_nettype wire

// ===== dv/csb_host_test.sv
/* Self-checking bench for csb_host driven through its register port.
   Assumes the processor model with a boot clock divider of 8. */
`timescale 1ns/1ns
`default_nettype none
module csb_host_test
  import csb_pkg::*;
;
  logic          core_clk = 1'b0, rst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0;
  logic [7:0]    reg_addr = 8'h00;
  logic [31:0]   reg_wdata = 32'h0, reg_rdata, v;
  csb_pins_in_t  pins_in;
  csb_pins_out_t pins_out;
  int            errors = 0, compares = 0;

  csb_host u_dut (.core_clk(core_clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .pins_in(pins_in),
    .pins_out(pins_out));
  csb_dev_model #(.DIV(8)) u_dev (.core_clk(core_clk), .rst(rst), .pins_out(pins_out),
    .pins_in(pins_in));

  initial begin
    forever #4 core_clk = ~core_clk;
  end

  task automatic check(input string what, input logic [255:0] seen, input logic [255:0] exp);
    compares++;
    if (seen !== exp) begin
      errors++;
      $display("ERROR %s expected %0h seen %0h", what, exp, seen);
    end
  endtask

  task automatic tally_and_finish;
    $display("compares %0d errors %0d", compares, errors);
    if (errors == 0 && compares > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
    @(posedge core_clk);
  endtask

  // Read data stand only in the cycle after the strobe
  task automatic rd(input logic [7:0] a);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    @(negedge core_clk);
    v = reg_rdata;
    @(posedge core_clk);
  endtask

  task automatic wait_oe(input logic lvl);
    int n;
    for (n = 0; n < 300 && pins_out.bus_oe !== lvl; n++) @(posedge core_clk);
    if (n == 300) begin
      check("bus_oe wait", 1'b0, 1'b1);
      tally_and_finish();
    end
  endtask

  task automatic read_case(input logic [63:0] a, input logic blk, input logic w32, input int nb);
    u_dev.beat_ad.delete();
    u_dev.beat_t.delete();
    u_dev.do_read(a, blk);
    wait_oe(1'b1);
    wait_oe(1'b0);
    check("beat count", u_dev.beat_ad.size(), nb);
    foreach (u_dev.beat_ad[i]) begin
      check("beat data", u_dev.beat_ad[i], {w32 ? 32'h0 : 32'h1000, 32'h1000 + i});
      if (i > 0) check("beat gap", u_dev.beat_t[i] - u_dev.beat_t[i-1], 2);
    end
    rd(REG_ADDR);
    check("request address", v, a[31:0]);
  endtask

  initial begin
    repeat (100000) @(posedge core_clk);
    check("run time", 1'b0, 1'b1);
    tally_and_finish();
  end

  initial begin
    repeat (4) @(posedge core_clk);
    rst <= 1'b0;
    @(posedge core_clk);
    // Read-only and unmapped writes must leave everything at reset
    wr(8'h20, 32'hffff_ffff);
    wr(REG_STAT, 32'hffff_ffff);
    for (int a = 0; a <= 32; a += 4) begin
      rd(8'(a));
      check("reset value", v, 8'(a) == REG_CTRL ? 32'h6 : 32'h0);
    end
    $display("test register reset done");
    wr(REG_CFG, 32'h1b5);
    wr(REG_CTRL, 32'h7);
    for (int n = 0; n < 3000 && u_dev.nbits < CFG_BITS; n++) @(posedge core_clk);
    check("boot bits", u_dev.nbits, CFG_BITS);
    check("boot stream", u_dev.stream, 256'h66a);
    repeat (20) @(posedge core_clk);
    check("serial bit after boot", pins_out.mode_data, 1'b0);
    rd(REG_STAT);
    check("status booted", v, 32'h3);
    $display("test boot stream done");
    wr(REG_RDATA, 32'h1000);
    wr(REG_GAP, 32'h1);
    read_case(64'h2460, 1'b1, 1'b0, 4);
    read_case(64'h2465, 1'b0, 1'b0, 1);
    wr(REG_CFG, 32'h3b5);
    read_case(64'h2478, 1'b1, 1'b1, 8);
    $display("test reads done");
    wr(REG_CTRL, 32'h3);
    fork
      u_dev.do_write(64'h80, 64'h1234_5678_9abc_def0);
      begin
        repeat (6) @(posedge core_clk);
        wr(REG_CTRL, 32'h7);
      end
    join
    repeat (2) @(posedge core_clk);
    rd(REG_CNT);
    check("write counts", v, {u_dev.drops[15:0], 16'h1});
    check("writes refused", u_dev.drops > 0, 1'b1);
    rd(REG_WDATA);
    check("write data", v, 32'h9abc_def0);
    $display("test write reissue done");
    wr(REG_CTRL, 32'hf);
    wait_oe(1'b1);
    rd(REG_STAT);
    check("owner status", v[4:3], 2'b11);
    wr(REG_CTRL, 32'h7);
    wait_oe(1'b0);
    check("null command", u_dev.null_seen, 1'b1);
    rd(REG_STAT);
    check("released status", v[4:3], 2'b00);
    $display("test external request done");
    // Supply drop and second boot into pipelined-write mode
    wr(REG_CTRL, 32'h6);
    wr(REG_CFG, 32'h135);
    wr(REG_CTRL, 32'h7);
    for (int n = 0; n < 3000 && u_dev.nbits < CFG_BITS; n++) @(posedge core_clk);
    check("reboot bits", u_dev.nbits, CFG_BITS);
    check("reboot stream", u_dev.stream, 256'h46a);
    fork
      begin
        u_dev.do_write(64'h88, 64'h1);
        u_dev.do_write(64'h90, 64'h2);
        u_dev.do_write(64'h98, 64'h3);
      end
      begin
        wr(REG_CTRL, 32'h3);
        repeat (6) @(posedge core_clk);
        wr(REG_CTRL, 32'h7);
      end
    join
    repeat (2) @(posedge core_clk);
    rd(REG_CNT);
    check("pipe write counts", v, {u_dev.drops[15:0], 16'h4});
    rd(REG_WDATA);
    check("pipe write data", v, 32'h3);
    $display("test pipelined writes done");
    tally_and_finish();
  end
endmodule // csb_host_test
`default_nettype wire
